//--- inc/gsf_regs.svh
// Function codes, flag bit positions, error codes and thresholds
`ifndef GSF_REGS_SVH
`define GSF_REGS_SVH
`define GSF_FC_MAX_ERROR   8'h0c
`define GSF_FC_FLAGS       8'h2f
`define GSF_FC_FINAL_END_OF_DISCHARGE_FLAG_VOLT   8'h3f
`define GSF_FC_SOFT_RESET  8'h44
`define GSF_FC_BATT_STATUS 8'h16
`define GSF_RESET_KEY      16'h1f49
`define GSF_MAXERR_BLOCK   16'h0002
`define GSF_U_DISPLAY_MODE_SELECT        7
`define GSF_U_CHM          5
`define GSF_U_CC           4
`define GSF_U_OV           2
`define GSF_U_LTF          1
`define GSF_U_OC           0
`define GSF_L_VQ           5
`define GSF_L_WRITE_INHIBIT_FLAG        4
`define GSF_L_VDQ          3
`define GSF_L_STOP_END_OF_DISCHARGE_FLAG         2
`define GSF_L_FIRST_END_OF_DISCHARGE_FLAG         1
`define GSF_L_FINAL_END_OF_DISCHARGE_FLAG         0
`define GSF_UPPER_WMASK    8'hb0
`define GSF_LOWER_WMASK    8'h10
`define GSF_ERR_OK         4'h0
`define GSF_ERR_BUSY       4'h1
`define GSF_ERR_NOTREADY   4'h2
`define GSF_ERR_UNSUP      4'h3
`define GSF_ERR_DENIED     4'h4
`define GSF_ERR_OVERFLOW   4'h5
`define GSF_ERR_BADSIZE    4'h6
`define GSF_ERR_UNKNOWN    4'h7
`define GSF_OC_KNEE_MA     16'h0400
`define GSF_OC_MARGIN_MA   16'h0100
`define GSF_STOP_END_OF_DISCHARGE_FLAG_MA        16'h1806
`define GSF_LTF_SET_DC     16'h0000
`define GSF_LTF_CLR_DC     16'h0032
`define GSF_VQ_MAH         16'h000a
`define GSF_SELF_DIS_MAH   16'h0100
`endif

//--- inc/gsf_pkg.sv
// Types shared by the status-flag bank
package gsf_pkg;
	// One decoded host transaction from the serial front end
	typedef struct packed {
		logic        req;
		logic        wr;
		logic [7:0]  code;
		logic [15:0] data;
		logic        size_ok;
		logic        busy;
		logic        not_ready;
		logic        overflow;
		logic        unknown;
	} gsf_cmd_t;
	// Analog measurements, signed temperature in tenths of a degree
	typedef struct packed {
		logic [15:0]        pack_mv;
		logic [15:0]        charge_mv;
		logic [15:0]        avg_ma;
		logic [15:0]        charge_ma;
		logic [15:0]        dis_ma;
		logic signed [15:0] temp_dc;
		logic [15:0]        first_end_of_discharge_flag_mv;
		logic [15:0]        final_end_of_discharge_flag_mv;
		logic [15:0]        chg_mah;
		logic [15:0]        self_dis_mah;
		logic               charging;
		logic               discharging;
		logic               rm_eq_fcc;
		logic               partial_chg;
	} gsf_meas_t;
	// Reset sequence progress
	typedef enum logic [0:0] {GSF_IDLE, GSF_ARMED} gsf_rst_st_t;
endpackage

//--- core/gsf_flags.sv
// Status-flag bank, error code and software reset of the gas gauge
`timescale 1ns/1ps
`include "gsf_regs.svh"
// Function
// RULE_01 - 0x2f reads upper then lower flag byte
// RULE_02 - Upper bit7 selects absolute or relative display
// RULE_03 - Upper bit5 selects nickel or lithium factors
// RULE_04 - Upper bit4 loads capacity on termination
// RULE_05 - Overvoltage sets 1.05x, clears 5% below
// RULE_06 - Low temp sets below 0, clears above 5
// RULE_07 - Overcurrent: 25% over, or 256mA below 1024mA
// RULE_08 - Overcurrent clears only below 256mA
// RULE_09 - Valid charge: charging plus 10mAh accumulated
// RULE_10 - Write inhibit blocks every register write
// RULE_11 - Host sets inhibit at assembly, verifies it
// RULE_12 - Valid discharge set after full, cleared variously
// RULE_13 - Stop flag follows discharge above 6.15A
// RULE_14 - First EDV flag threshold with hysteresis
// RULE_15 - Final EDV flag threshold with hysteresis
// RULE_16 - 0x3f returns programmed final EDV millivolts
// RULE_17 - Host reset: check inhibit, 0x0c, then 0x44
// RULE_18 - Reset key reloads defaults from EEPROM
// RULE_19 - Codes 0, 3, 7 for ok, unsupported, unknown
// RULE_20 - Codes 4 read-only write, 6 bad size
// RULE_21 - Codes 1 busy, 2 not ready, 5 overflow
// RULE_22 - Error code in status word low nibble
// RULE_23 - Any read after error clears code
// RULE_24 - Reserved flag bits read zero
module gsf_flags (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire gsf_pkg::gsf_cmd_t  cmd,
	input  wire gsf_pkg::gsf_meas_t meas,
	input  wire logic [15:0]        eeprom_final_end_of_discharge_flag_mv,
	input  wire logic [15:0]        eeprom_flags,
	input  wire logic [15:0]        status_hi,
	output logic [15:0]             rd_data,
	output logic                    rd_valid,
	output logic [3:0]              err_code,
	output logic                    reload_req,
	output logic                    display_mode_select,
	output logic                    chemistry_select,
	output logic                    charge_control_enable
);
	import gsf_pkg::*;

	////////////////////////////////////////////////////////////////
	// Flag state
	logic [7:0]  upper_flag_byte_r;   // EEPROM-loaded upper controls
	logic [7:0]  lower_flag_byte_r;   // EEPROM-loaded lower control
	logic        ov_r, ltf_r, oc_r;   // Measured upper flags
	logic        vq_r, vdq_r, stop_end_of_discharge_flag_r; // Measured lower flags
	logic        first_end_of_discharge_flag_r, final_end_of_discharge_flag_r;
	logic [3:0]  err_r;               // Stored error code
	logic [15:0] max_error_word_r;    // Writable error word
	gsf_rst_st_t rst_st_r;            // Reset sequence state
	logic [15:0] rd_data_r;
	logic        rd_valid_r;
	logic        reload_r;

	////////////////////////////////////////////////////////////////
	// Thresholds; voltages scaled by 20 so 1.05x and 0.95x stay whole,
	// with room for the full 16-bit range so no product can wrap
	wire [21:0] pv20   = 22'(meas.pack_mv) * 22'd20;
	wire [21:0] cv21   = 22'(meas.charge_mv) * 22'd21;
	wire [21:0] cv19   = 22'(meas.charge_mv) * 22'd19;
	wire        ov_hi  = pv20 >= cv21;
	wire        ov_lo  = pv20 < cv19;
	// Current compared as 4x average against 5x charging current
	wire [19:0] ia4    = {2'b00, meas.avg_ma, 2'b00};
	wire [19:0] ic5    = 20'(meas.charge_ma) * 20'd5;
	wire [16:0] ic_mg  = {1'b0, meas.charge_ma}
	                     + {1'b0, `GSF_OC_MARGIN_MA};
	wire        low_ic = meas.charge_ma < `GSF_OC_KNEE_MA;
	// Below the knee a fixed margin replaces the 25% one
	wire        oc_hi  = low_ic ? ({1'b0, meas.avg_ma} > ic_mg)
	                     : (ia4 > ic5);
	wire        oc_lo  = meas.avg_ma < `GSF_OC_MARGIN_MA;
	wire        lt_set = meas.temp_dc < $signed(`GSF_LTF_SET_DC);
	wire        lt_clr = meas.temp_dc > $signed(`GSF_LTF_CLR_DC);
	wire        stop_end_of_discharge_flag_n = meas.dis_ma > `GSF_STOP_END_OF_DISCHARGE_FLAG_MA;
	wire        vq_set = meas.charging && meas.chg_mah >= `GSF_VQ_MAH;
	wire        vq_clr = meas.discharging || !meas.charging;
	wire        first_end_of_discharge_flag_s = meas.pack_mv < meas.first_end_of_discharge_flag_mv && !stop_end_of_discharge_flag_r;
	wire        first_end_of_discharge_flag_c = vq_r && meas.pack_mv > meas.first_end_of_discharge_flag_mv;
	wire        final_end_of_discharge_flag_s = meas.pack_mv < meas.final_end_of_discharge_flag_mv && !stop_end_of_discharge_flag_r;
	wire        final_end_of_discharge_flag_c = vq_r && meas.pack_mv > meas.final_end_of_discharge_flag_mv;
	wire        vdq_s  = meas.discharging && meas.rm_eq_fcc;
	wire        vdq_c  = meas.partial_chg || (first_end_of_discharge_flag_s && lt_set)
	                     || meas.self_dis_mah > `GSF_SELF_DIS_MAH;

	////////////////////////////////////////////////////////////////
	// Host access decode
	wire inhibit   = lower_flag_byte_r[`GSF_L_WRITE_INHIBIT_FLAG];
	wire is_rd     = cmd.req && !cmd.wr;
	wire is_wr     = cmd.req && cmd.wr;
	wire fc_flags  = cmd.code == `GSF_FC_FLAGS;
	wire fc_final_end_of_discharge_flag   = cmd.code == `GSF_FC_FINAL_END_OF_DISCHARGE_FLAG_VOLT;
	wire fc_maxerr = cmd.code == `GSF_FC_MAX_ERROR;
	wire fc_rst    = cmd.code == `GSF_FC_SOFT_RESET;
	wire fc_stat   = cmd.code == `GSF_FC_BATT_STATUS;
	wire known_rd  = fc_flags || fc_final_end_of_discharge_flag || fc_maxerr || fc_stat;
	wire known     = known_rd || fc_rst;
	wire wr_ro     = fc_flags || fc_final_end_of_discharge_flag || fc_stat;
	wire [7:0] up_v = {upper_flag_byte_r[7], 1'b0,
	                   upper_flag_byte_r[5:4], 1'b0, ov_r, ltf_r, oc_r};
	wire [7:0] lo_v = {2'b00, vq_r, inhibit, vdq_r, stop_end_of_discharge_flag_r,
	                   first_end_of_discharge_flag_r, final_end_of_discharge_flag_r}; // RULE_24
	wire [15:0] flag_word = {up_v, lo_v}; // RULE_01
	// Control defaults from the EEPROM; reserved bits never load
	wire [7:0] up_dflt = eeprom_flags[15:8] & `GSF_UPPER_WMASK; // RULE_24
	wire [7:0] lo_dflt = eeprom_flags[7:0] & `GSF_LOWER_WMASK;  // RULE_24

	// Error precedence: busy and not-ready first, front-end overflow and unknown last
	logic [3:0] err_nxt;
	always_comb begin
		err_nxt = err_r;
		if (cmd.req) begin
			if (cmd.busy)
				err_nxt = `GSF_ERR_BUSY;          // RULE_21
			else if (cmd.not_ready)
				err_nxt = `GSF_ERR_NOTREADY;      // RULE_21
			else if (!known)
				err_nxt = `GSF_ERR_UNSUP;         // RULE_19
			else if (is_wr && (wr_ro || (!fc_rst && !fc_maxerr)))
				err_nxt = `GSF_ERR_DENIED;        // RULE_20
			else if (is_rd && fc_rst)
				err_nxt = `GSF_ERR_DENIED;
			else if (is_wr && !cmd.size_ok)
				err_nxt = `GSF_ERR_BADSIZE;       // RULE_20
			else if (cmd.overflow)
				err_nxt = `GSF_ERR_OVERFLOW;      // RULE_21
			else if (cmd.unknown)
				err_nxt = `GSF_ERR_UNKNOWN;       // RULE_19
			else
				err_nxt = `GSF_ERR_OK;            // RULE_19 RULE_23
		end
	end
	wire wr_ok = is_wr && !inhibit && err_nxt == `GSF_ERR_OK; // RULE_10
	wire key_hit = wr_ok && fc_rst && cmd.data == `GSF_RESET_KEY;

	////////////////////////////////////////////////////////////////
	// Measured flags, stop flag without hysteresis; set wins over clear except on vdq_r
	always_ff @(posedge clk) begin
		if (rst || reload_r) begin
			{ov_r, ltf_r, oc_r, vq_r} <= 4'h0;
			{vdq_r, stop_end_of_discharge_flag_r, first_end_of_discharge_flag_r, final_end_of_discharge_flag_r} <= 4'h0;
		end else begin
			ov_r   <= ov_hi ? 1'b1 : (ov_lo ? 1'b0 : ov_r);    // RULE_05
			ltf_r  <= lt_set ? 1'b1 : (lt_clr ? 1'b0 : ltf_r); // RULE_06
			oc_r   <= oc_hi ? 1'b1 : (oc_lo ? 1'b0 : oc_r); // RULE_07 RULE_08
			vq_r   <= vq_set ? 1'b1 : (vq_clr ? 1'b0 : vq_r);  // RULE_09
			stop_end_of_discharge_flag_r <= stop_end_of_discharge_flag_n;                                  // RULE_13
			first_end_of_discharge_flag_r <= first_end_of_discharge_flag_s ? 1'b1 : (first_end_of_discharge_flag_c ? 1'b0 : first_end_of_discharge_flag_r); // RULE_14
			final_end_of_discharge_flag_r <= final_end_of_discharge_flag_s ? 1'b1 : (final_end_of_discharge_flag_c ? 1'b0 : final_end_of_discharge_flag_r); // RULE_15
			vdq_r  <= vdq_c ? 1'b0 : (vdq_s ? 1'b1 : vdq_r);   // RULE_12
		end
	end

	// EEPROM-loaded controls, host-writable error word and the reset sequence
	always_ff @(posedge clk) begin
		if (rst || reload_r) begin
			upper_flag_byte_r <= up_dflt; // RULE_18
			lower_flag_byte_r <= lo_dflt; // RULE_10
			max_error_word_r  <= 16'h0000;
			rst_st_r          <= GSF_IDLE;
		end else if (wr_ok) begin
			if (fc_maxerr) begin
				max_error_word_r <= cmd.data;
				rst_st_r <= (cmd.data != `GSF_MAXERR_BLOCK)
				            ? GSF_ARMED : GSF_IDLE; // RULE_17
			end else if (fc_rst)
				rst_st_r <= GSF_IDLE;
		end
	end

	// Reload pulse, error store and read data
	always_ff @(posedge clk) begin
		if (rst) begin
			reload_r   <= 1'b0;
			err_r      <= `GSF_ERR_OK;
			rd_data_r  <= 16'h0000;
			rd_valid_r <= 1'b0;
		end else begin
			reload_r   <= key_hit && rst_st_r == GSF_ARMED; // RULE_18
			err_r      <= err_nxt;                          // RULE_23
			rd_valid_r <= is_rd && known_rd && !cmd.busy;
			if (is_rd && fc_flags)
				rd_data_r <= flag_word;                     // RULE_01
			else if (is_rd && fc_final_end_of_discharge_flag)
				rd_data_r <= eeprom_final_end_of_discharge_flag_mv;                // RULE_16
			else if (is_rd && fc_maxerr)
				rd_data_r <= max_error_word_r;
			else if (is_rd && fc_stat)
				rd_data_r <= {status_hi[15:4], err_r};      // RULE_22
		end
	end

	assign rd_data               = rd_data_r;
	assign rd_valid              = rd_valid_r;
	assign err_code              = err_r;
	assign reload_req            = reload_r;
	assign display_mode_select   = upper_flag_byte_r[`GSF_U_DISPLAY_MODE_SELECT]; // RULE_02
	assign chemistry_select      = upper_flag_byte_r[`GSF_U_CHM];   // RULE_03
	assign charge_control_enable = upper_flag_byte_r[`GSF_U_CC];    // RULE_04

	////////////////////////////////////////////////////////////////
	// Checks
	stop_end_of_discharge_flag_follow_a: assert property ( // RULE_13
		@(posedge clk) disable iff (rst)
		!reload_r |=> stop_end_of_discharge_flag_r == $past(stop_end_of_discharge_flag_n))
		else $error("stop flag does not follow current");
	inhibit_block_a: assert property ( // RULE_10
		@(posedge clk) disable iff (rst)
		is_wr && inhibit |=> !reload_r)
		else $error("write accepted while inhibited");
	// A blocked write must leave the writable word as it was
	inhibit_hold_a: assert property ( // RULE_10
		@(posedge clk) disable iff (rst)
		is_wr && inhibit && !reload_r
		|=> max_error_word_r == $past(max_error_word_r))
		else $error("error word written while inhibited");
	flag_read_a: assert property ( // RULE_24
		@(posedge clk) disable iff (rst)
		is_rd && fc_flags && !cmd.busy |=> rd_data_r[14] == 1'b0
		&& rd_data_r[11] == 1'b0 && rd_data_r[7:6] == 2'b00)
		else $error("reserved flag bits not zero");
	unsup_code_a: assert property ( // RULE_19
		@(posedge clk) disable iff (rst)
		cmd.req && !cmd.busy && !cmd.not_ready && !known
		|=> err_r == `GSF_ERR_UNSUP)
		else $error("unsupported code not reported");
	busy_code_a: assert property ( // RULE_21
		@(posedge clk) disable iff (rst)
		cmd.req && cmd.busy |=> err_r == `GSF_ERR_BUSY)
		else $error("busy not reported");
	final_end_of_discharge_flag_read_a: assert property ( // RULE_16
		@(posedge clk) disable iff (rst)
		is_rd && fc_final_end_of_discharge_flag && !cmd.busy
		|=> rd_data_r == $past(eeprom_final_end_of_discharge_flag_mv))
		else $error("final voltage read wrong");
	oc_hold_a: assert property ( // RULE_08
		@(posedge clk) disable iff (rst || reload_r)
		oc_r && !oc_lo |=> oc_r)
		else $error("overcurrent cleared early");
	// Set wins over clear, so the flag follows the set threshold
	ov_set_a: assert property ( // RULE_05
		@(posedge clk) disable iff (rst || reload_r)
		ov_hi |=> ov_r)
		else $error("overvoltage flag not set");
	sequence armed_s;
		rst_st_r == GSF_ARMED && key_hit;
	endsequence
	// Reload reads the control defaults again, not plain zeros
	reset_seq_a: assert property ( // RULE_18
		@(posedge clk) disable iff (rst)
		armed_s |=> reload_r ##1 upper_flag_byte_r == $past(up_dflt))
		else $error("reset sequence did not reload");
endmodule

//--- verification/gsf_host.sv
// Host-side model that issues decoded transactions to the flag bank
`timescale 1ns/1ps
`include "gsf_regs.svh"
module gsf_host (
	input  wire logic        clk,
	output gsf_pkg::gsf_cmd_t cmd
);
	import gsf_pkg::*;
	////////////////////////////////////////////////////////////////////
	// Idle until the bench asks for a transfer
	initial cmd = '0;
	// One request as a single-cycle pulse; f is busy,nr,ovf,unknown
	task automatic xfer(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic ok, input logic [3:0] f);
		@(posedge clk);
		cmd <= '{1'b1, w, c, d, ok, f[3], f[2], f[1], f[0]};
		@(posedge clk);
		cmd.req <= 1'b0;
	endtask
	// Key only counts after a max-error write other than 2
	task automatic soft_reset(input logic [15:0] m);
		xfer(1'b1, `GSF_FC_MAX_ERROR, m, 1'b1, 4'h0);
		xfer(1'b1, `GSF_FC_SOFT_RESET, `GSF_RESET_KEY, 1'b1, 4'h0);
	endtask
endmodule

//--- verification/gsf_flags_test.sv
// Self-checking bench for the status-flag bank
`timescale 1ns/1ps
`include "gsf_regs.svh"
module gsf_flags_test;
	import gsf_pkg::*;
	// Expected answer of one request
	typedef struct packed {
		logic [3:0]  err;
		logic        rd;
		logic [15:0] data;
		logic        rel;
	} gsf_exp_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	gsf_cmd_t    cmd;
	gsf_meas_t   meas = '0;
	gsf_meas_t   mv = '0;
	logic [15:0] final_end_of_discharge_flag_mv = 16'h0000;
	logic [15:0] status_hi = 16'h0000;
	logic [15:0] eeprom_flags = 16'h0000;
	logic        disp;
	logic        chem;
	logic        cctl;
	logic [15:0] rd_data;
	logic        rd_valid;
	logic [3:0]  err_code;
	logic        reload_req;
	logic        taken_r = 1'b0;
	int          fails = 0;
	int          num_checks = 0;
	int          cycles = 0;
	gsf_exp_t    exp_q[$];
	gsf_exp_t    e;
	// Front-end fault inputs and the code each must give
	logic [3:0]  f_in [5] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hf};
	logic [3:0]  f_er [5] = '{4'h1, 4'h2, 4'h5, 4'h7, 4'h1};
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////
	gsf_host i_gsf_host (.clk(clk), .cmd(cmd));
	gsf_flags i_gsf_flags (
		.clk                  (clk),
		.rst                  (rst),
		.cmd                  (cmd),
		.meas                 (meas),
		.eeprom_final_end_of_discharge_flag_mv       (final_end_of_discharge_flag_mv),
		.eeprom_flags         (eeprom_flags),
		.status_hi            (status_hi),
		.rd_data              (rd_data),
		.rd_valid             (rd_valid),
		.err_code             (err_code),
		.reload_req           (reload_req),
		.display_mode_select  (disp),
		.chemistry_select     (chem),
		.charge_control_enable(cctl)
	);
	////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic report(input logic ok, input logic [15:0] g, x);
		num_checks++;
		if (!ok) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic cmp_data(input logic [15:0] g, x);
		report(g === x, g, x);
	endtask
	task automatic cmp_err(input logic [3:0] g, x);
		report(g === x, {12'h000, g}, {12'h000, x});
	endtask
	task automatic cmp_pulse(input logic g, x);
		report(g === x, {15'h0000, g}, {15'h0000, x});
	endtask
	// Note the answer, then hand the request to the host model
	task automatic tx(input logic w, input logic [7:0] c,
		input logic [15:0] d, input logic ok, input logic [3:0] f,
		input logic [3:0] er, input logic rl);
		exp_q.push_back('{er, ~w & (er == 4'h0), d, rl});
		i_gsf_host.xfer(w, c, d, ok, f);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] x);
		tx(1'b0, c, x, 1'b1, 4'h0, `GSF_ERR_OK, 1'b0);
	endtask
	// Apply mv, let the flags settle, read the flag word
	task automatic probe(input logic [15:0] x);
		@(posedge clk);
		meas <= mv;
		repeat (3) @(posedge clk);
		rd(`GSF_FC_FLAGS, x);
	endtask
	////////////////////////////////////////////////////////////////////
	// Answer is registered on the edge that takes the request; judge at mid-cycle
	always @(posedge clk) taken_r <= cmd.req;
	always @(negedge clk) begin
		if (taken_r === 1'b1) begin
			if (exp_q.size() == 0)
				cmp_pulse(1'b1, 1'b0);
			else begin
				e = exp_q.pop_front();
				cmp_err(err_code, e.err);
				cmp_pulse(reload_req, e.rel);
				// A clean answer flags read data only for reads
				if (e.err == 4'h0)
					cmp_pulse(rd_valid, e.rd);
				if (e.rd)
					cmp_data(rd_data, e.data);
			end
		end
	end
	// Hang guard, well above the roughly 180 cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h3cfa6230));
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		final_end_of_discharge_flag_mv <= $urandom;
		status_hi <= $urandom;
		mv.charge_mv = 16'h07d0;
		mv.pack_mv = 16'h05dc;
		mv.temp_dc = 16'sh0064;
		probe(16'h0000);
		rd(`GSF_FC_FINAL_END_OF_DISCHARGE_FLAG_VOLT, final_end_of_discharge_flag_mv);
		rd(`GSF_FC_BATT_STATUS, {status_hi[15:4], 4'h0});
		// Low temperature with hysteresis between 0 and 5 degrees
		mv.temp_dc = -16'sd1;
		probe(16'h0200);
		mv.temp_dc = 16'sh0032;
		probe(16'h0200);
		mv.temp_dc = 16'sh0033;
		probe(16'h0000);
		// Overvoltage at 1.05x, holds down to 0.95x
		mv.pack_mv = 16'h0834;
		probe(16'h0400);
		mv.pack_mv = 16'h076c;
		probe(16'h0400);
		mv.pack_mv = 16'h076b;
		probe(16'h0000);
		// Overcurrent, both margin branches and the 256mA release
		mv.charge_ma = 16'h0200;
		mv.avg_ma = 16'h0300;
		probe(16'h0000);
		mv.avg_ma = 16'h0301;
		probe(16'h0100);
		mv.avg_ma = 16'h0100;
		probe(16'h0100);
		mv.avg_ma = 16'h00ff;
		probe(16'h0000);
		mv.charge_ma = 16'h0800;
		mv.avg_ma = 16'h0a00;
		probe(16'h0000);
		mv.avg_ma = 16'h0a01;
		probe(16'h0100);
		mv.avg_ma = 16'h0000;
		probe(16'h0000);
		// Stop flag masks both end-of-discharge flags; it is raised
		// first, since the mask acts on the registered stop flag
		mv.dis_ma = 16'h1807;
		probe(16'h0004);
		mv.pack_mv = 16'h05dc;
		mv.first_end_of_discharge_flag_mv = 16'h0640;
		mv.final_end_of_discharge_flag_mv = 16'h0640;
		probe(16'h0004);
		mv.dis_ma = 16'h1805;
		probe(16'h0003);
		// Error codes, then a read clears them
		tx(1'b1, `GSF_FC_FLAGS, 16'h0000, 1'b1, 4'h0, 4'h4, 1'b0);
		rd(`GSF_FC_FLAGS, 16'h0003);
		tx(1'b1, 8'h0c, 16'h0001, 1'b0, 4'h0, 4'h6, 1'b0);
		tx(1'b0, 8'h55, 16'h0000, 1'b1, 4'h0, 4'h3, 1'b0);
		rd(`GSF_FC_BATT_STATUS, {status_hi[15:4], 4'h3});
		for (int i = 0; i < 5; i++)
			tx(1'b0, 8'h2f, 16'h0000, 1'b1, f_in[i], f_er[i], 1'b0);
		// Soft reset: wrong arming value first, then the real one
		rd(`GSF_FC_FLAGS, 16'h0003);
		exp_q.push_back('{4'h0, 1'b0, 16'h0002, 1'b0});
		exp_q.push_back('{4'h0, 1'b0, 16'h1f49, 1'b0});
		i_gsf_host.soft_reset(16'h0002);
		exp_q.push_back('{4'h0, 1'b0, 16'h0005, 1'b0});
		exp_q.push_back('{4'h0, 1'b0, 16'h1f49, 1'b1});
		i_gsf_host.soft_reset(16'h0005);
		// Valid charge clears both end-of-discharge flags above threshold
		mv.charging = 1'b1;
		mv.chg_mah = 16'h000a;
		mv.pack_mv = 16'h0641;
		probe(16'h0020);
		// Discharge from full drops valid charge, starts valid discharge
		mv.charging = 1'b0;
		mv.discharging = 1'b1;
		mv.rm_eq_fcc = 1'b1;
		probe(16'h0008);
		mv.partial_chg = 1'b1;
		probe(16'h0000);
		// Mid-run reset loads controls and write inhibit from the EEPROM
		eeprom_flags <= 16'hb010;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		probe(16'hb010);
		cmp_pulse(disp, 1'b1);
		cmp_pulse(chem, 1'b1);
		cmp_pulse(cctl, 1'b1);
		// Inhibit blocks both the arming write and the key
		exp_q.push_back('{4'h0, 1'b0, 16'h0005, 1'b0});
		exp_q.push_back('{4'h0, 1'b0, 16'h1f49, 1'b0});
		i_gsf_host.soft_reset(16'h0005);
		rd(`GSF_FC_MAX_ERROR, 16'h0000);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule
